// File: bench/tb.sv
// Self-checking bench for the flag and core control executor, driven over APB.
// Assumes the design answers with pready and shows instruction effects after the access edge.
module tb
    import flag_exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, sleep_req, wdt_restart, debug_halt;
    logic [7:0] status_flags;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h75aafd10;

    status_flag_instruction_exec status_flag_instruction_exec_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .status_flags(status_flags), .sleep_req(sleep_req), .wdt_restart(wdt_restart),
        .debug_halt(debug_halt)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // A hang is cut short well above the few thousand cycles the tests need.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // One APB transfer; the pulse outputs are sampled once the access edge has landed.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       output logic [31:0] rd, output logic err, output logic [2:0] pl);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        pl = {sleep_req, wdt_restart, debug_halt};
    endtask : apb

    // Flag register after one instruction; set and clear forms alternate by opcode parity.
    function automatic logic [7:0] exp_flags(input logic [4:0] op, input logic [2:0] b,
                                             input logic [7:0] rv, input logic [7:0] f);
        logic [2:0] idx [16] = '{7, 7, 4, 4, 3, 3, 5, 5, 0, 0, 2, 2, 1, 1, 6, 6};
        if (op == 5'h01) f[b] = 1'b1;
        else if (op == 5'h02) f[b] = 1'b0;
        else if (op == 5'h03) f[FLAG_T] = rv[b];
        else if (op >= 5'h05 && op <= 5'h14) f[idx[op - 5'h05]] = op[0];
        return f;
    endfunction : exp_flags

    initial begin
        logic [31:0] rd;
        logic err;
        logic [2:0] pl, ep;
        logic [4:0] op, r;
        logic [2:0] b;
        logic [7:0] f, v, ef, ev;
        logic [15:0] cnt;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        cnt = 16'h0000;
        repeat (10) @(posedge pclk);
        check(32'(status_flags), 32'(STATUS_RESET), "reset flags");
        presetn <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err, pl);
        check(rd, 32'h0, "status after reset");
        for (int k = 0; k < 200; k++) begin
            op = (k < 24) ? 5'(k) : 5'(rnd() % 24);
            b = 3'(rnd());
            r = 5'(rnd());
            f = 8'(rnd());
            v = 8'(rnd());
            apb(1'b1, ADDR_STATUS, 32'(f), rd, err, pl);
            apb(1'b1, 8'h80 | {1'b0, r, 2'b00}, 32'(v), rd, err, pl);
            ef = exp_flags(op, b, v, f);
            ev = v;
            if (op == 5'h04) ev[b] = f[FLAG_T];
            ep = (op == 5'h15) ? 3'b100 : (op == 5'h16) ? 3'b010 : (op == 5'h17) ? 3'b001 : 3'b000;
            apb(1'b1, ADDR_INSTR, 32'(op) | (32'(b) << 8) | (32'(r) << 16), rd, err, pl);
            cnt = cnt + 16'h0001;
            check(32'(err), 32'h0, "legal opcode refused");
            check(32'(pl), 32'(ep), "request pulses");
            check(32'(status_flags), 32'(ef), "flags");
            // One edge later every request pulse must already be gone again.
            @(posedge pclk);
            #1;
            check(32'({sleep_req, wdt_restart, debug_halt}), 32'h0, "pulse lasted past one cycle");
            apb(1'b0, 8'h80 | {1'b0, r, 2'b00}, 32'h0, rd, err, pl);
            check(rd, 32'(ev), "working register");
        end
        f = status_flags;
        apb(1'b1, ADDR_INSTR, 32'h18 + (rnd() % 8), rd, err, pl);
        check(32'(err), 32'h1, "illegal opcode accepted");
        check(32'(status_flags), 32'(f), "illegal opcode moved flags");
        apb(1'b0, ADDR_INFO, 32'h0, rd, err, pl);
        check(rd, 32'(cnt), "executed count");
        apb(1'b0, 8'h0c, 32'h0, rd, err, pl);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        apb(1'b0, 8'h81, 32'h0, rd, err, pl);
        check({rd[30:0], err}, 32'h1, "misaligned read");
        apb(1'b0, ADDR_INSTR, 32'h0, rd, err, pl);
        check({rd[30:0], err}, 32'h0, "instruction read");
        end_sim();
    end
endmodule : tb

// File: hdl/status_flag_instruction_exec.sv
// Executor for flag, bit-transfer and core control instructions behind an APB slave.
// Assumes an APB master on pclk; sleep, watchdog and debug logic take the request pulses.
module status_flag_instruction_exec
    import flag_exec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] status_flags,
    output logic sleep_req,
    output logic wdt_restart,
    output logic debug_halt
);
    core_state_t st;
    core_state_t next_st;
    instr_t ins;
    logic setup;
    logic access;
    logic mapped;
    logic op_legal;
    logic go;
    logic picked;

    // The instruction word keeps its fields apart, so each one is picked out by position.
    assign ins = '{reg_sel: pwdata[REG_LSB +: 5], bit_sel: pwdata[BIT_LSB +: 3],
        op: opcode_t'(pwdata[OP_LSB +: 5])};
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr[WREG_SEL_BIT] || paddr == ADDR_INSTR
        || paddr == ADDR_STATUS || paddr == ADDR_INFO);
    assign op_legal = pwdata[OP_LSB+4:OP_LSB] <= OP_LAST;
    // Every instruction finishes at the edge that completes its APB write.
    assign go = access && pwrite && paddr == ADDR_INSTR && op_legal;
    assign picked = st.wregs[ins.reg_sel][ins.bit_sel];

    // The slave never stalls, so each access phase is one cycle long.
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && paddr == ADDR_INSTR && !op_legal));
    assign prdata = st.rdata;
    assign status_flags = st.status_flags_register;
    assign sleep_req = st.sleep_req;
    assign wdt_restart = st.wdt_restart;
    assign debug_halt = st.debug_halt;

    always_comb begin
        next_st = st;
        next_st.sleep_req = 1'b0;
        next_st.wdt_restart = 1'b0;
        next_st.debug_halt = 1'b0;
        // Read data is captured in the setup cycle so that it leaves a flip-flop.
        if (setup && !pwrite) begin
            next_st.rdata = 32'h0000_0000;
            if (paddr[WREG_SEL_BIT] && paddr[1:0] == 2'h0) begin
                next_st.rdata = {24'h00_0000, st.wregs[paddr[6:2]]};
            end else if (paddr == ADDR_STATUS) begin
                next_st.rdata = {24'h00_0000, st.status_flags_register};
            end else if (paddr == ADDR_INFO) begin
                next_st.rdata = {16'h0000, st.exec_count};
            end
        end
        if (access && pwrite && paddr == ADDR_STATUS) begin
            next_st.status_flags_register = pwdata[7:0];
        end
        if (access && pwrite && paddr[WREG_SEL_BIT] && paddr[1:0] == 2'h0) begin
            next_st.wregs[paddr[6:2]] = pwdata[7:0];
        end
        if (go) begin
            next_st.exec_count = st.exec_count + 16'h0001;
            unique case (ins.op)
                OP_NOP: begin
                    next_st.exec_count = st.exec_count + 16'h0001; // [RULE14]
                end
                OP_GENERIC_FLAG_SET: begin
                    next_st.status_flags_register[ins.bit_sel] = 1'b1; // [RULE13]
                end
                OP_GENERIC_FLAG_CLEAR: begin
                    next_st.status_flags_register[ins.bit_sel] = 1'b0; // [RULE13]
                end
                OP_BIT_STORE: begin
                    next_st.status_flags_register[FLAG_T] = picked; // [RULE1]
                end
                OP_BIT_LOAD: begin
                    next_st.wregs[ins.reg_sel][ins.bit_sel] =
                        st.status_flags_register[FLAG_T]; // [RULE2]
                end
                OP_INTERRUPT_ENABLE: begin
                    next_st.status_flags_register[FLAG_I] = 1'b1; // [RULE3]
                end
                OP_INTERRUPT_DISABLE: begin
                    next_st.status_flags_register[FLAG_I] = 1'b0; // [RULE4]
                end
                OP_SIGN_SET: begin
                    next_st.status_flags_register[FLAG_S] = 1'b1; // [RULE5]
                end
                OP_SIGN_CLEAR: begin
                    next_st.status_flags_register[FLAG_S] = 1'b0; // [RULE6]
                end
                OP_OVERFLOW_SET: begin
                    next_st.status_flags_register[FLAG_V] = 1'b1; // [RULE7]
                end
                OP_OVERFLOW_CLEAR: begin
                    next_st.status_flags_register[FLAG_V] = 1'b0; // [RULE8]
                end
                OP_HALF_CARRY_SET: begin
                    next_st.status_flags_register[FLAG_H] = 1'b1; // [RULE9]
                end
                OP_HALF_CARRY_CLEAR: begin
                    next_st.status_flags_register[FLAG_H] = 1'b0; // [RULE9]
                end
                OP_CARRY_SET: begin
                    next_st.status_flags_register[FLAG_C] = 1'b1; // [RULE13]
                end
                OP_CARRY_CLEAR: begin
                    next_st.status_flags_register[FLAG_C] = 1'b0; // [RULE13]
                end
                OP_NEGATIVE_SET: begin
                    next_st.status_flags_register[FLAG_N] = 1'b1; // [RULE13]
                end
                OP_NEGATIVE_CLEAR: begin
                    next_st.status_flags_register[FLAG_N] = 1'b0; // [RULE13]
                end
                OP_ZERO_SET: begin
                    next_st.status_flags_register[FLAG_Z] = 1'b1; // [RULE13]
                end
                OP_ZERO_CLEAR: begin
                    next_st.status_flags_register[FLAG_Z] = 1'b0; // [RULE13]
                end
                OP_TRANSFER_SET: begin
                    next_st.status_flags_register[FLAG_T] = 1'b1; // [RULE13]
                end
                OP_TRANSFER_CLEAR: begin
                    next_st.status_flags_register[FLAG_T] = 1'b0; // [RULE13]
                end
                OP_SLEEP: begin
                    next_st.sleep_req = 1'b1; // [RULE10]
                end
                OP_WATCHDOG_RESTART: begin
                    next_st.wdt_restart = 1'b1; // [RULE11]
                end
                OP_BREAK: begin
                    // The halt request is all that break does; the debug unit decides the rest.
                    next_st.debug_halt = 1'b1; // [RULE12]
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{status_flags_register: STATUS_RESET, wregs: '0, exec_count: COUNT_RESET,
                rdata: 32'h0000_0000, sleep_req: 1'b0, wdt_restart: 1'b0, debug_halt: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_bit_store;
        go && ins.op == OP_BIT_STORE |=> status_flags[FLAG_T] == $past(picked)
            && (status_flags & 8'hbf) == ($past(status_flags) & 8'hbf);
    endproperty
    a_bit_store: assert property (p_bit_store) else $error("bit store wrong"); // [RULE1]

    property p_bit_load;
        go && ins.op == OP_BIT_LOAD |=> st.wregs[$past(ins.reg_sel)][$past(ins.bit_sel)]
            == $past(status_flags[FLAG_T]) && $stable(status_flags);
    endproperty
    a_bit_load: assert property (p_bit_load) else $error("bit load wrong"); // [RULE2]

    property p_int_enable;
        go && ins.op == OP_INTERRUPT_ENABLE |=> status_flags == ($past(status_flags) | 8'h80);
    endproperty
    a_int_enable: assert property (p_int_enable) else $error("enable wrong"); // [RULE3]

    property p_int_disable;
        go && ins.op == OP_INTERRUPT_DISABLE |=> status_flags == ($past(status_flags) & 8'h7f);
    endproperty
    a_int_disable: assert property (p_int_disable) else $error("disable wrong"); // [RULE4]

    property p_sign_set;
        go && ins.op == OP_SIGN_SET |=> status_flags == ($past(status_flags) | 8'h10);
    endproperty
    a_sign_set: assert property (p_sign_set) else $error("sign set wrong"); // [RULE5]

    property p_sign_clear;
        go && ins.op == OP_SIGN_CLEAR |=> status_flags == ($past(status_flags) & 8'hef);
    endproperty
    a_sign_clear: assert property (p_sign_clear) else $error("sign clear wrong"); // [RULE6]

    property p_ovf_set;
        go && ins.op == OP_OVERFLOW_SET |=> status_flags == ($past(status_flags) | 8'h08);
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow set wrong"); // [RULE7]

    property p_ovf_clear;
        go && ins.op == OP_OVERFLOW_CLEAR |=> status_flags == ($past(status_flags) & 8'hf7);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow clear wrong"); // [RULE8]

    property p_half_carry;
        go && ins.op == OP_HALF_CARRY_CLEAR |=> status_flags == ($past(status_flags) & 8'hdf);
    endproperty
    a_half_carry: assert property (p_half_carry) else $error("half carry wrong"); // [RULE9]

    property p_half_carry_set;
        go && ins.op == OP_HALF_CARRY_SET |=> status_flags == ($past(status_flags) | 8'h20);
    endproperty
    a_half_carry_set: assert property (p_half_carry_set) else $error("half carry set wrong"); // [RULE9]

    property p_sleep;
        go && ins.op == OP_SLEEP |=> sleep_req && $stable(status_flags) ##1 !sleep_req;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep request wrong"); // [RULE10]

    property p_wdt;
        wdt_restart |-> $past(go) && $past(ins.op) == OP_WATCHDOG_RESTART
            && $stable(status_flags);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog pulse wrong"); // [RULE11]

    property p_sleep_cause;
        sleep_req |-> $past(go) && $past(ins.op) == OP_SLEEP
            && $stable(status_flags);
    endproperty
    a_sleep_cause: assert property (p_sleep_cause) else $error("stray sleep request"); // [RULE10]

    property p_halt_cause;
        debug_halt |-> $past(go) && $past(ins.op) == OP_BREAK
            && $stable(status_flags);
    endproperty
    a_halt_cause: assert property (p_halt_cause) else $error("stray halt request"); // [RULE12]

    property p_break;
        go && ins.op == OP_BREAK |=> debug_halt && $stable(status_flags) && !sleep_req;
    endproperty
    a_break: assert property (p_break) else $error("break wrong"); // [RULE12]

    property p_generic_set;
        go && ins.op == OP_GENERIC_FLAG_SET |=> status_flags
            == ($past(status_flags) | (8'h01 << $past(ins.bit_sel)));
    endproperty
    a_generic_set: assert property (p_generic_set) else $error("flag set wrong"); // [RULE13]

    property p_generic_clear;
        go && ins.op == OP_GENERIC_FLAG_CLEAR |=> status_flags
            == ($past(status_flags) & ~(8'h01 << $past(ins.bit_sel)));
    endproperty
    a_generic_clear: assert property (p_generic_clear) else $error("flag clear wrong"); // [RULE13]

    property p_carry_set;
        go && ins.op == OP_CARRY_SET |=> status_flags == ($past(status_flags) | 8'h01);
    endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry set wrong"); // [RULE13]

    property p_carry_clear;
        go && ins.op == OP_CARRY_CLEAR |=> status_flags == ($past(status_flags) & 8'hfe);
    endproperty
    a_carry_clear: assert property (p_carry_clear) else $error("carry clear wrong"); // [RULE13]

    property p_zero_set;
        go && ins.op == OP_ZERO_SET |=> status_flags == ($past(status_flags) | 8'h02);
    endproperty
    a_zero_set: assert property (p_zero_set) else $error("zero set wrong"); // [RULE13]

    property p_zero_clear;
        go && ins.op == OP_ZERO_CLEAR |=> status_flags == ($past(status_flags) & 8'hfd);
    endproperty
    a_zero_clear: assert property (p_zero_clear) else $error("zero clear wrong"); // [RULE13]

    property p_negative_set;
        go && ins.op == OP_NEGATIVE_SET |=> status_flags == ($past(status_flags) | 8'h04);
    endproperty
    a_negative_set: assert property (p_negative_set) else $error("negative set wrong"); // [RULE13]

    property p_negative_clear;
        go && ins.op == OP_NEGATIVE_CLEAR |=> status_flags == ($past(status_flags) & 8'hfb);
    endproperty
    a_negative_clear: assert property (p_negative_clear) else $error("negative clear wrong"); // [RULE13]

    property p_transfer_set;
        go && ins.op == OP_TRANSFER_SET |=> status_flags == ($past(status_flags) | 8'h40);
    endproperty
    a_transfer_set: assert property (p_transfer_set) else $error("transfer set wrong"); // [RULE13]

    property p_transfer_clear;
        go && ins.op == OP_TRANSFER_CLEAR |=> status_flags == ($past(status_flags) & 8'hbf);
    endproperty
    a_transfer_clear: assert property (p_transfer_clear) else $error("transfer clear wrong"); // [RULE13]

    // Every legal instruction, no-operation included, moves the executed count by one.
    property p_exec_count;
        go |=> st.exec_count == $past(st.exec_count) + 16'h0001;
    endproperty
    a_exec_count: assert property (p_exec_count) else $error("executed count wrong"); // [RULE14]

    property p_nop;
        go && ins.op == OP_NOP |=> $stable(status_flags) && $stable(st.wregs);
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state"); // [RULE14]

    c_bit_store: cover property (go && ins.op == OP_BIT_STORE && picked);
    c_bit_load: cover property (go && ins.op == OP_BIT_LOAD);
    c_sleep: cover property (go && ins.op == OP_SLEEP ##2 go && ins.op == OP_WATCHDOG_RESTART);
    c_bad_op: cover property (pslverr);
endmodule : status_flag_instruction_exec

// File: include/flag_exec_pkg.sv
// Constants, opcodes and carriers for the status flag and core control executor.
// Assumes a 40 MHz APB clock and that software issues one instruction per APB write.
// How it works
// RULE1: Bit-store copies the chosen bit of a working register into the transfer flag only, in one clock.
// RULE2: Bit-load writes the transfer flag into the chosen bit of a working register, no flags move, one clock.
// RULE3: Interrupt-enable sets the global interrupt flag and nothing else in one clock.
// RULE4: Interrupt-disable clears the global interrupt flag and nothing else in one clock.
// RULE5: Sign-set forces the signed test flag to one and nothing else in one clock.
// RULE6: Sign-clear forces the signed test flag to zero and nothing else in one clock.
// RULE7: Overflow-set forces the overflow flag to one and nothing else in one clock.
// RULE8: Overflow-clear forces the overflow flag to zero and nothing else in one clock.
// RULE9: Half-carry set and clear force the half carry flag to one or zero and nothing else in one clock.
// RULE10: Sleep issues a request to the sleep logic in one clock and leaves every flag alone.
// RULE11: Watchdog restart pulses the watchdog restart request in one clock and leaves every flag alone.
// RULE12: Break only raises a debug halt request and leaves every flag alone.
// RULE13: Generic and named flag set or clear write one or zero to the flag picked by a three-bit index.
// RULE14: No-operation takes one clock and changes no register or flag; the code still advances the executed count by one.
package flag_exec_pkg;
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INFO = 8'h08;
    localparam int WREG_SEL_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam int OP_LSB = 0;
    localparam int BIT_LSB = 8;
    localparam int REG_LSB = 16;
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_GENERIC_FLAG_SET = 5'h01,
        OP_GENERIC_FLAG_CLEAR = 5'h02,
        OP_BIT_STORE = 5'h03,
        OP_BIT_LOAD = 5'h04,
        OP_INTERRUPT_ENABLE = 5'h05,
        OP_INTERRUPT_DISABLE = 5'h06,
        OP_SIGN_SET = 5'h07,
        OP_SIGN_CLEAR = 5'h08,
        OP_OVERFLOW_SET = 5'h09,
        OP_OVERFLOW_CLEAR = 5'h0a,
        OP_HALF_CARRY_SET = 5'h0b,
        OP_HALF_CARRY_CLEAR = 5'h0c,
        OP_CARRY_SET = 5'h0d,
        OP_CARRY_CLEAR = 5'h0e,
        OP_NEGATIVE_SET = 5'h0f,
        OP_NEGATIVE_CLEAR = 5'h10,
        OP_ZERO_SET = 5'h11,
        OP_ZERO_CLEAR = 5'h12,
        OP_TRANSFER_SET = 5'h13,
        OP_TRANSFER_CLEAR = 5'h14,
        OP_SLEEP = 5'h15,
        OP_WATCHDOG_RESTART = 5'h16,
        OP_BREAK = 5'h17
    } opcode_t;

    localparam logic [4:0] OP_LAST = 5'h17;

    typedef struct packed {
        logic [4:0] reg_sel;
        logic [2:0] bit_sel;
        opcode_t op;
    } instr_t;

    typedef struct packed {
        logic [7:0] status_flags_register;
        logic [31:0][7:0] wregs;
        logic [15:0] exec_count;
        logic [31:0] rdata;
        logic sleep_req;
        logic wdt_restart;
        logic debug_halt;
    } core_state_t;
endpackage : flag_exec_pkg
